// >>> hdl/cbe_pkg.sv
// Constants, encodings and types shared by the branch and transfer core
package cbe_pkg;

  // ----------------------------------------------------------------------
  // Widths and register file shape
  // ----------------------------------------------------------------------
  localparam int DW    = 8;   // Register and data byte width
  localparam int IW    = 16;  // Instruction word width
  localparam int PW    = 16;  // Pointer and data address width
  localparam int NREG  = 32;  // General purpose registers
  localparam int QW    = 6;   // Displacement width, 0 to 63
  localparam int OFF_W = 7;   // Signed branch offset width

  // Program counter steps
  localparam int PC_INC     = 1;  // One-word instruction
  localparam int PC_INC_ABS = 2;  // Instruction with address word

  // Pointer step and reset values
  localparam logic [PW-1:0] PTR_STEP  = 16'h0001;
  localparam logic [DW-1:0] GPR_RST   = 8'h00;
  localparam logic [PW-1:0] ADDR_RST  = 16'h0000;

  // Pointer pair low registers, high byte at the next index, then register 0
  localparam logic [4:0] R_XL = 5'h1A;
  localparam logic [4:0] R_YL = 5'h1C;
  localparam logic [4:0] R_ZL = 5'h1E;
  localparam logic [4:0] R_R0 = 5'h00;

  // Status flag bit positions
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;

  // ----------------------------------------------------------------------
  // Opcode fields
  // ----------------------------------------------------------------------
  localparam logic [5:0]  OP_BR_SET   = 6'h3C;   // Branch if flag set
  localparam logic [5:0]  OP_BR_CLR   = 6'h3D;   // Branch if flag clear
  localparam logic [5:0]  OP_MOV      = 6'h0B;   // reg_copy
  localparam logic [7:0]  OP_REG_PAIR_COPY     = 8'h01;   // reg_pair_copy
  localparam logic [3:0]  OP_LDI      = 4'hE;    // load_constant
  localparam logic [3:0]  OP_LDST     = 4'h9;    // Pointer/absolute group
  localparam logic [1:0]  OP_LDST_SUB = 2'h0;
  localparam logic [1:0]  OP_DISP     = 2'h2;    // Displacement group
  localparam logic [15:0] OP_LPM      = 16'h95C8; // program_memory_read

  // Addressing modes in the low nibble of the pointer group
  localparam logic [3:0] M_ABS  = 4'h0;
  localparam logic [3:0] M_ZINC = 4'h1;
  localparam logic [3:0] M_ZDEC = 4'h2;
  localparam logic [3:0] M_YINC = 4'h9;
  localparam logic [3:0] M_YDEC = 4'hA;
  localparam logic [3:0] M_X    = 4'hC;
  localparam logic [3:0] M_XINC = 4'hD;
  localparam logic [3:0] M_XDEC = 4'hE;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PTR_X = 2'b00,
    PTR_Y = 2'b01,
    PTR_Z = 2'b10
  } cbe_ptr_t;

  typedef enum logic [1:0] {
    S_EXEC   = 2'b00,
    S_LOAD   = 2'b01,
    S_BUBBLE = 2'b10,
    S_LPM    = 2'b11
  } cbe_state_t;

endpackage : cbe_pkg

// >>> hdl/cbe_ex_if.sv
// Interface between the core and its branch and address units
`timescale 1ns/1ps
interface cbe_ex_if import cbe_pkg::*; #(parameter int PC_W = 16) ();
  logic [IW-1:0]   instr;
  logic [IW-1:0]   kword;
  logic [DW-1:0]   flags;
  logic [PC_W-1:0] pc;
  logic [PW-1:0]   x;
  logic [PW-1:0]   y;
  logic [PW-1:0]   z;
  logic            br_hit;
  logic            br_taken;
  logic [PC_W-1:0] br_target;
  logic            ag_hit;
  logic            ag_store;
  logic            ag_abs;
  logic            ag_ptr_wr;
  cbe_ptr_t        ag_ptr_sel;
  logic [PW-1:0]   ag_addr;
  logic [PW-1:0]   ag_ptr_new;

  modport core (
    output instr, kword, flags, pc, x, y, z,
    input  br_hit, br_taken, br_target,
    input  ag_hit, ag_store, ag_abs, ag_ptr_wr, ag_ptr_sel, ag_addr,
    input  ag_ptr_new
  );
  modport br (
    input  instr, flags, pc,
    output br_hit, br_taken, br_target
  );
  modport ag (
    input  instr, kword, x, y, z,
    output ag_hit, ag_store, ag_abs, ag_ptr_wr, ag_ptr_sel, ag_addr,
    output ag_ptr_new
  );
endinterface : cbe_ex_if

// >>> hdl/cbe_branch_unit.sv
// Conditional relative branch decode, flag test and target
`timescale 1ns/1ps
module cbe_branch_unit import cbe_pkg::*; #(
  parameter int PC_W = 16
) (
  cbe_ex_if.br ex
);

  // ----------------------------------------------------------------------
  // Decode and flag selection
  // ----------------------------------------------------------------------
  wire             is_set  = (ex.instr[15:10] == OP_BR_SET);
  wire             is_clr  = (ex.instr[15:10] == OP_BR_CLR);
  wire [2:0]       sel     = ex.instr[2:0];
  wire             n_xor_v = ex.flags[FLAG_N] ^ ex.flags[FLAG_V];
  // Signed test looks at N xor V directly
  wire             flag_v  = (sel == FLAG_S) ? n_xor_v : ex.flags[sel];
  wire [OFF_W-1:0] off     = ex.instr[9:3];
  wire [PC_W-1:0]  off_ext = {{(PC_W-OFF_W){off[OFF_W-1]}}, off};

  // ----------------------------------------------------------------------
  // Outcome and target, flags are only read here
  // ----------------------------------------------------------------------
  assign ex.br_hit    = is_set | is_clr;
  assign ex.br_taken  = (is_clr & ~flag_v) | (is_set & flag_v);
  assign ex.br_target = ex.pc + off_ext + PC_W'(PC_INC);

endmodule : cbe_branch_unit

// >>> hdl/cbe_addr_gen.sv
// Data address and pointer update for pointer, offset and absolute access
`timescale 1ns/1ps
module cbe_addr_gen import cbe_pkg::*; (
  cbe_ex_if.ag ex
);

  // ----------------------------------------------------------------------
  // Group and mode decode
  // ----------------------------------------------------------------------
  wire [3:0]    mode   = ex.instr[3:0];
  wire          is_grp = (ex.instr[15:12] == OP_LDST) &&
                         (ex.instr[11:10] == OP_LDST_SUB);
  wire          is_dsp = (ex.instr[15:14] == OP_DISP) && !ex.instr[12];
  wire          m_x    = mode inside {M_X, M_XINC, M_XDEC};
  wire          m_y    = mode inside {M_YINC, M_YDEC};
  wire          m_z    = mode inside {M_ZINC, M_ZDEC};
  wire          m_abs  = (mode == M_ABS);
  wire          m_inc  = mode inside {M_XINC, M_YINC, M_ZINC};
  wire          m_dec  = mode inside {M_XDEC, M_YDEC, M_ZDEC};
  wire          ind    = is_grp & (m_x | m_y | m_z);
  wire [QW-1:0] q      = {ex.instr[13], ex.instr[11:10], ex.instr[2:0]};

  // ----------------------------------------------------------------------
  // Pointer selection, offset form only on the second and third pair
  // ----------------------------------------------------------------------
  wire cbe_ptr_t sel = is_dsp ? (ex.instr[3] ? PTR_Y : PTR_Z) :
                       m_x ? PTR_X : m_y ? PTR_Y : PTR_Z;
  wire [PW-1:0] cur  = (sel == PTR_X) ? ex.x :
                       (sel == PTR_Y) ? ex.y : ex.z;
  wire [PW-1:0] dec_v = cur - PTR_STEP;
  wire [PW-1:0] inc_v = cur + PTR_STEP;

  // ----------------------------------------------------------------------
  // Outputs to the core
  // ----------------------------------------------------------------------
  assign ex.ag_hit     = ind | is_dsp | (is_grp & m_abs);
  assign ex.ag_store   = ex.instr[9];
  assign ex.ag_abs     = is_grp & m_abs;
  assign ex.ag_ptr_sel = sel;
  // Pre-decrement accesses the decremented address
  assign ex.ag_addr    = is_dsp ? cur + PW'(q) :
                         m_abs  ? ex.kword :
                         m_dec  ? dec_v : cur;
  assign ex.ag_ptr_wr  = ind & (m_inc | m_dec);
  assign ex.ag_ptr_new = m_dec ? dec_v : inc_v;

endmodule : cbe_addr_gen

// >>> hdl/cbe_exec_core.sv
// Execution core for conditional branches and data transfer instructions
//
// How it works
// - Flag bit clear branches to PC plus offset plus one
// - Zero set or clear branches, same target
// - Carry set or clear branches, also unsigned compare
// - Negative set or clear branches
// - Signed compare branches on N xor V
// - Half carry set or clear branches
// - User transfer flag set or clear branches
// - Overflow flag set or clear branches
// - Interrupt enable flag branches; branches never touch flags
// - Register copy, pair copy, constant load: one cycle
// - Pointer loads with post-increment or pre-decrement, two cycles
// - Offset loads via second or third pointer, two cycles
// - Absolute load from address word, two cycles
// - Pointer stores with post-increment or pre-decrement, two cycles
// - Offset stores, pointer unchanged, two cycles
// - Absolute store to address word, two cycles
`timescale 1ns/1ps
module cbe_exec_core import cbe_pkg::*; #(
  parameter int PC_W = 16
) (
  input  wire logic            i_clk_sys,
  input  wire logic            i_srst,
  input  wire logic [IW-1:0]   i_pm_word,
  input  wire logic [IW-1:0]   i_pm_next,
  output logic      [PC_W-1:0] o_pm_addr,
  input  wire logic [DW-1:0]   i_status_flags,
  output logic      [PW-1:0]   o_dm_addr,
  output logic      [DW-1:0]   o_dm_wdata,
  output logic                 o_dm_we,
  output logic                 o_dm_re,
  input  wire logic [DW-1:0]   i_dm_rdata
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  cbe_state_t      state_r;
  cbe_state_t      state_nxt;
  logic [PC_W-1:0] pc_r;
  logic [PC_W-1:0] pc_nxt;
  logic [PC_W-1:0] pm_addr_r;
  logic [PC_W-1:0] pm_addr_nxt;
  logic [PW-1:0]   dm_addr_r;
  logic [PW-1:0]   dm_addr_nxt;
  logic [DW-1:0]   dm_wdata_r;
  logic [DW-1:0]   dm_wdata_nxt;
  logic            dm_we_r;
  logic            dm_we_nxt;
  logic            dm_re_r;
  logic            dm_re_nxt;
  logic [4:0]      ld_dst_r;
  logic [4:0]      ld_dst_nxt;
  logic            lpm_hi_r;
  logic            lpm_hi_nxt;
  logic [DW-1:0]   gpr_r [NREG];

  // Two register write ports
  logic            wa_en;
  logic [4:0]      wa_idx;
  logic [DW-1:0]   wa_dat;
  logic            wb_en;
  logic [4:0]      wb_idx;
  logic [DW-1:0]   wb_dat;

  cbe_ex_if #(.PC_W(PC_W)) ex ();

  // ----------------------------------------------------------------------
  // Operand decode
  // ----------------------------------------------------------------------
  wire [IW-1:0] instr   = i_pm_word;
  wire          is_mov  = (instr[15:10] == OP_MOV);
  wire          is_reg_pair_copy = (instr[15:8] == OP_REG_PAIR_COPY);
  wire          is_ldi  = (instr[15:12] == OP_LDI);
  wire          is_lpm  = (instr == OP_LPM);
  wire [4:0]    rd      = instr[8:4];
  wire [4:0]    rr      = {instr[9], instr[3:0]};
  wire [4:0]    ldi_d   = {1'b1, instr[7:4]};
  wire [DW-1:0] kconst  = {instr[11:8], instr[3:0]};
  wire [4:0]    pw_d    = {instr[7:4], 1'b0};
  wire [4:0]    pw_r    = {instr[3:0], 1'b0};
  wire [4:0]    ptr_lo  = (ex.ag_ptr_sel == PTR_X) ? R_XL :
                          (ex.ag_ptr_sel == PTR_Y) ? R_YL : R_ZL;
  wire [PW-1:0] z_ptr   = {gpr_r[R_ZL + 5'h01], gpr_r[R_ZL]};
  wire [DW-1:0] lpm_b   = lpm_hi_r ? i_pm_word[15:8] : i_pm_word[7:0];
  wire          lpm_go  = (state_r == S_EXEC) && is_lpm;

  // ----------------------------------------------------------------------
  // Unit connections
  // ----------------------------------------------------------------------
  assign ex.instr = instr;
  assign ex.kword = i_pm_next;
  assign ex.flags = i_status_flags;
  assign ex.pc    = pc_r;
  assign ex.x     = {gpr_r[R_XL + 5'h01], gpr_r[R_XL]};
  assign ex.y     = {gpr_r[R_YL + 5'h01], gpr_r[R_YL]};
  assign ex.z     = z_ptr;

  cbe_branch_unit #(.PC_W(PC_W)) u_branch (
    .ex (ex.br)
  );

  cbe_addr_gen u_addr (
    .ex (ex.ag)
  );

  // Program memory address follows the PC except during a byte read
  assign pm_addr_nxt = lpm_go ? PC_W'(z_ptr[PW-1:1]) : pc_nxt;

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt    = S_EXEC;
    pc_nxt       = pc_r;
    dm_addr_nxt  = dm_addr_r;
    dm_wdata_nxt = dm_wdata_r;
    dm_we_nxt    = 1'b0;
    dm_re_nxt    = 1'b0;
    ld_dst_nxt   = ld_dst_r;
    lpm_hi_nxt   = lpm_hi_r;
    wa_en        = 1'b0;
    wa_idx       = rd;
    wa_dat       = GPR_RST;
    wb_en        = 1'b0;
    wb_idx       = rd;
    wb_dat       = GPR_RST;
    case (state_r)
      S_EXEC: begin
        pc_nxt = pc_r + PC_W'(PC_INC);
        if (ex.br_hit && ex.br_taken) begin
          pc_nxt    = ex.br_target;
          state_nxt = S_BUBBLE;
        end else if (ex.ag_hit) begin
          if (ex.ag_abs) begin
            pc_nxt = pc_r + PC_W'(PC_INC_ABS);
          end
          dm_addr_nxt = ex.ag_addr;
          // Pointer write-back happens in the first cycle
          wa_en  = ex.ag_ptr_wr;
          wa_idx = ptr_lo;
          wa_dat = ex.ag_ptr_new[DW-1:0];
          wb_en  = ex.ag_ptr_wr;
          wb_idx = ptr_lo + 5'h01;
          wb_dat = ex.ag_ptr_new[PW-1:DW];
          if (ex.ag_store) begin
            dm_we_nxt    = 1'b1;
            dm_wdata_nxt = gpr_r[rd];
            state_nxt    = S_BUBBLE;
          end else begin
            dm_re_nxt  = 1'b1;
            ld_dst_nxt = rd;
            state_nxt  = S_LOAD;
          end
        end else if (is_mov) begin
          wa_en  = 1'b1;
          wa_dat = gpr_r[rr];
        end else if (is_reg_pair_copy) begin
          wa_en  = 1'b1;
          wa_idx = pw_d;
          wa_dat = gpr_r[pw_r];
          wb_en  = 1'b1;
          wb_idx = pw_d + 5'h01;
          wb_dat = gpr_r[pw_r + 5'h01];
        end else if (is_ldi) begin
          wa_en  = 1'b1;
          wa_idx = ldi_d;
          wa_dat = kconst;
        end else if (is_lpm) begin
          lpm_hi_nxt = z_ptr[0];
          state_nxt  = S_LPM;
        end
      end
      S_LOAD: begin
        wa_en  = 1'b1;
        wa_idx = ld_dst_r;
        wa_dat = i_dm_rdata;
      end
      S_LPM: begin
        wa_en     = 1'b1;
        wa_idx    = R_R0;
        wa_dat    = lpm_b;
        state_nxt = S_BUBBLE;
      end
      S_BUBBLE: begin
        state_nxt = S_EXEC;
      end
      default: begin
        state_nxt = S_EXEC;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Control and memory port registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_r    <= S_EXEC;
      pc_r       <= '0;
      pm_addr_r  <= '0;
      dm_addr_r  <= ADDR_RST;
      dm_wdata_r <= GPR_RST;
      dm_we_r    <= 1'b0;
      dm_re_r    <= 1'b0;
      ld_dst_r   <= R_R0;
      lpm_hi_r   <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      pc_r       <= pc_nxt;
      pm_addr_r  <= pm_addr_nxt;
      dm_addr_r  <= dm_addr_nxt;
      dm_wdata_r <= dm_wdata_nxt;
      dm_we_r    <= dm_we_nxt;
      dm_re_r    <= dm_re_nxt;
      ld_dst_r   <= ld_dst_nxt;
      lpm_hi_r   <= lpm_hi_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Register file, port A wins if both ports hit one register
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < NREG; g++) begin : g_gpr
    always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
        gpr_r[g] <= GPR_RST;
      end else if (wa_en && (wa_idx == 5'(g))) begin
        gpr_r[g] <= wa_dat;
      end else if (wb_en && (wb_idx == 5'(g))) begin
        gpr_r[g] <= wb_dat;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign o_pm_addr  = pm_addr_r;
  assign o_dm_addr  = dm_addr_r;
  assign o_dm_wdata = dm_wdata_r;
  assign o_dm_we    = dm_we_r;    // Write strobe, second store cycle
  assign o_dm_re    = dm_re_r;    // Read strobe, second load cycle

endmodule : cbe_exec_core

// >>> testbench/cbe_exec_core_sva.sv
// Port level assertions for the branch and transfer core
`timescale 1ns/1ps
module cbe_exec_core_sva import cbe_pkg::*; #(
  parameter int PC_W = 16
) (
  input wire logic            i_clk_sys,
  input wire logic            i_srst,
  input wire logic [IW-1:0]   i_pm_word,
  input wire logic [IW-1:0]   i_pm_next,
  input wire logic [PC_W-1:0] o_pm_addr,
  input wire logic [DW-1:0]   i_status_flags,
  input wire logic [PW-1:0]   o_dm_addr,
  input wire logic [DW-1:0]   o_dm_wdata,
  input wire logic            o_dm_we,
  input wire logic            o_dm_re,
  input wire logic [DW-1:0]   i_dm_rdata
);
  // ----------------------------------------------------------------------
  // Shadow decode of the word being executed
  // ----------------------------------------------------------------------
  logic            skip_r;
  logic            skip_nxt;
  logic            lpm_r;
  wire  [IW-1:0]   pw      = i_pm_word;
  wire             is_br   = (pw[15:10] == OP_BR_SET) ||
                             (pw[15:10] == OP_BR_CLR);
  wire             nv      = i_status_flags[FLAG_N] ^ i_status_flags[FLAG_V];
  wire             fsel    = (pw[2:0] == FLAG_S) ? nv : i_status_flags[pw[2:0]];
  wire             taken   = is_br && (pw[10] ? !fsel : fsel);
  wire             mode_ok = pw[3:0] inside {M_ABS, M_ZINC, M_ZDEC, M_YINC,
                                             M_YDEC, M_X, M_XINC, M_XDEC};
  wire             is_ls   = (pw[15:12] == OP_LDST) &&
                             (pw[11:10] == OP_LDST_SUB) && mode_ok;
  wire             is_dsp  = (pw[15:14] == OP_DISP) && !pw[12];
  wire             exec_w  = !skip_r;
  wire             mem_op  = exec_w && (is_ls || is_dsp);
  wire             abs_op  = mem_op && is_ls && (pw[3:0] == M_ABS);
  wire             one_op  = exec_w && ((pw[15:10] == OP_MOV) ||
                             (pw[15:8] == OP_REG_PAIR_COPY) || (pw[15:12] == OP_LDI));
  wire             is_lpm  = exec_w && (pw == OP_LPM);
  wire  [PC_W-1:0] tgt     = o_pm_addr + PC_W'(signed'(pw[9:3])) + PC_W'(1);

  assign skip_nxt = (exec_w && (taken || is_ls || is_dsp || is_lpm)) || lpm_r;

  // Later cycles of two and three cycle instructions are not execute cycles
  always_ff @(posedge i_clk_sys) begin
    skip_r <= i_srst ? 1'b0 : skip_nxt;
    lpm_r  <= i_srst ? 1'b0 : is_lpm;
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  sequence s_jump;
    (o_pm_addr == $past(tgt)) ##1 $stable(o_pm_addr);
  endsequence
  sequence s_read;
    (o_dm_re && !o_dm_we) ##1 !o_dm_re;
  endsequence
  sequence s_write;
    (o_dm_we && !o_dm_re) ##1 !o_dm_we;
  endsequence
  // Program address back at PC plus one, then one bubble
  sequence s_lpm_back;
    (o_pm_addr == $past(o_pm_addr, 2) + PC_W'(1)) ##1 $stable(o_pm_addr);
  endsequence

  property p_reset;
    disable iff (1'b0) i_srst |=> (o_pm_addr == '0) && !o_dm_we && !o_dm_re &&
                                  (o_dm_addr == ADDR_RST);
  endproperty
  property p_br_taken;
    exec_w && taken |=> s_jump;
  endproperty
  property p_br_not;
    exec_w && is_br && !taken |=> o_pm_addr == $past(o_pm_addr) + PC_W'(1);
  endproperty
  property p_load;
    mem_op && !pw[9] |=> s_read;
  endproperty
  property p_store;
    mem_op && pw[9] |=> s_write;
  endproperty
  property p_abs;
    abs_op |=> (o_dm_addr == $past(i_pm_next)) &&
               (o_pm_addr == $past(o_pm_addr) + PC_W'(2));
  endproperty
  property p_ptr_pc;
    mem_op && !abs_op |=> o_pm_addr == $past(o_pm_addr) + PC_W'(1);
  endproperty
  property p_one;
    one_op |=> (o_pm_addr == $past(o_pm_addr) + PC_W'(1)) &&
               !o_dm_we && !o_dm_re;
  endproperty
  property p_excl;
    !(o_dm_we && o_dm_re);
  endproperty
  property p_lpm;
    is_lpm |=> ##1 s_lpm_back;
  endproperty

  a_reset:    assert property (p_reset)
    else $error("reset state wrong");
  a_br_taken: assert property (p_br_taken)
    else $error("taken branch wrong");
  a_br_not:   assert property (p_br_not)
    else $error("untaken branch wrong");
  a_load:     assert property (p_load)
    else $error("load strobe wrong");
  a_store:    assert property (p_store)
    else $error("store strobe wrong");
  a_abs:      assert property (p_abs)
    else $error("absolute access wrong");
  a_ptr_pc:   assert property (p_ptr_pc)
    else $error("pointer access pc wrong");
  a_one:      assert property (p_one)
    else $error("one cycle op wrong");
  a_excl:     assert property (p_excl)
    else $error("both strobes high");
  a_lpm:      assert property (p_lpm)
    else $error("program byte read timing wrong");
endmodule : cbe_exec_core_sva

bind cbe_exec_core cbe_exec_core_sva #(.PC_W(PC_W)) u_cbe_exec_core_sva (
  .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_pm_word(i_pm_word),
  .i_pm_next(i_pm_next), .o_pm_addr(o_pm_addr),
  .i_status_flags(i_status_flags), .o_dm_addr(o_dm_addr),
  .o_dm_wdata(o_dm_wdata), .o_dm_we(o_dm_we), .o_dm_re(o_dm_re),
  .i_dm_rdata(i_dm_rdata)
);

// >>> testbench/tb.sv
// Self-checking bench for the branch and transfer core
`timescale 1ns/1ps
module tb import cbe_pkg::*;;
  localparam int PC_W = 16;
  logic            i_clk_sys;
  logic            i_srst;
  logic [IW-1:0]   i_pm_word;
  logic [IW-1:0]   i_pm_next;
  logic [PC_W-1:0] o_pm_addr;
  logic [DW-1:0]   i_status_flags;
  logic [PW-1:0]   o_dm_addr;
  logic [DW-1:0]   o_dm_wdata;
  logic            o_dm_we;
  logic            o_dm_re;
  logic [DW-1:0]   i_dm_rdata;
  logic [IW-1:0]   rom [0:63];
  logic [DW-1:0]   dmem [0:65535];
  int              n_mismatch;
  int              checked;
  int              n_we;
  int              n_re;

  cbe_exec_core #(.PC_W(PC_W)) u_cbe_exec_core (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_pm_word(i_pm_word),
    .i_pm_next(i_pm_next), .o_pm_addr(o_pm_addr),
    .i_status_flags(i_status_flags), .o_dm_addr(o_dm_addr),
    .o_dm_wdata(o_dm_wdata), .o_dm_we(o_dm_we), .o_dm_re(o_dm_re),
    .i_dm_rdata(i_dm_rdata)
  );

  // Program and data memories with asynchronous read
  assign i_pm_word  = rom[o_pm_addr[5:0]];
  assign i_pm_next  = rom[6'(o_pm_addr[5:0] + 6'h01)];
  assign i_dm_rdata = dmem[o_dm_addr];
  always @(posedge i_clk_sys) begin
    if (o_dm_we === 1'b1) begin
      dmem[o_dm_addr] <= o_dm_wdata;
      n_we++;
    end
    if (o_dm_re === 1'b1) n_re++;
  end

  // Free running system clock
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end

  // ----------------------------------------------------------------------
  // Encoders and shared tasks
  // ----------------------------------------------------------------------
  function automatic logic [15:0] f_ldi(input logic [4:0] d,
                                        input logic [7:0] k);
    return {OP_LDI, k[7:4], d[3:0], k[3:0]};
  endfunction : f_ldi
  function automatic logic [15:0] f_ptr(input logic st, input logic [4:0] r,
                                        input logic [3:0] m);
    return {6'h24, st, r, m};
  endfunction : f_ptr
  function automatic logic [15:0] f_dsp(input logic st, input logic [4:0] r,
                                        input logic [5:0] q);
    return {OP_DISP, q[5], 1'h0, q[4:3], st, r, 1'h1, q[2:0]};
  endfunction : f_dsp

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic step();
    @(posedge i_clk_sys);
    #1;
  endtask : step

  task automatic do_reset(input logic [7:0] flg);
    @(posedge i_clk_sys);
    i_srst         <= 1'b1;
    i_status_flags <= flg;
    repeat (4) @(posedge i_clk_sys);
    i_srst <= 1'b0;
  endtask : do_reset

  task automatic wait_pc(input logic [15:0] a);
    int n;
    n = 0;
    while (o_pm_addr !== a && n < 100) begin
      step();
      n++;
    end
  endtask : wait_pc

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Every flag index, both forms, both flag values, forward and back
  task automatic t_branch();
    logic [6:0]  k;
    logic [7:0]  flg;
    logic        tk;
    logic [15:0] tgt;
    for (int s = 0; s < 8; s++) begin
      for (int f = 0; f < 2; f++) begin
        for (int v = 0; v < 2; v++) begin
          k = f[0] ? 7'h7B : 7'h09;
          flg = {8{~v[0]}};
          flg[s] = v[0];
          if (s == 4) begin
            flg[FLAG_S] = ~v[0];
            flg[FLAG_V] = f[0];
            flg[FLAG_N] = v[0] ^ f[0];
          end
          tk = f[0] ? !v[0] : v[0];
          tgt = tk ? 16'h0009 + {{9{k[6]}}, k} : 16'h0009;
          do_reset(flg);
          rom[8] = {f[0] ? OP_BR_CLR : OP_BR_SET, k, 3'(s)};
          wait_pc(16'h0008);
          step();
          chk(o_pm_addr, tgt);
          step();
          chk(o_pm_addr, tk ? tgt : 16'h000A);
        end
      end
    end
    rom[8] = 16'h0000;
    $display("t_branch done, mismatches %0d", n_mismatch);
  endtask : t_branch

  // Moves, pointer, offset and absolute loads and stores back to back
  task automatic t_transfer();
    logic [15:0] p [30];
    logic [15:0] ea [10];
    logic [7:0]  ev [10];
    int          n;
    p = '{f_ldi(5'h1A, 8'h10), f_ldi(5'h1B, 8'h01), f_ldi(5'h10, 8'hA5),
          f_ptr(1'h1, 5'h10, M_XINC), f_ptr(1'h0, 5'h11, M_XINC),
          f_ptr(1'h0, 5'h12, M_XDEC), f_ldi(5'h1C, 8'h20),
          f_ldi(5'h1D, 8'h02), f_dsp(1'h0, 5'h13, 6'h3F),
          f_dsp(1'h1, 5'h11, 6'h00), f_ptr(1'h1, 5'h12, M_ABS), 16'h0300,
          f_ptr(1'h0, 5'h14, M_ABS), 16'h0400, f_ptr(1'h1, 5'h13, M_ABS),
          16'h0301, f_ptr(1'h1, 5'h14, M_ABS), 16'h0302, 16'h01B9,
          {OP_MOV, 1'h1, 5'h18, 4'h7}, f_ptr(1'h1, 5'h16, M_ABS), 16'h0303,
          f_ptr(1'h1, 5'h18, M_ABS), 16'h0304, f_ldi(5'h1E, 8'h40),
          f_ldi(5'h1F, 8'h04), f_ptr(1'h1, 5'h10, M_ZINC),
          f_ptr(1'h0, 5'h15, M_ZDEC), f_ptr(1'h1, 5'h15, M_ABS), 16'h0305};
    ea = '{16'h0110, 16'h0111, 16'h0220, 16'h0300, 16'h0301,
           16'h0302, 16'h0303, 16'h0304, 16'h0440, 16'h0305};
    ev = '{8'hA5, 8'h2D, 8'h2D, 8'h2D, 8'h63,
           8'h3C, 8'h2D, 8'h63, 8'hA5, 8'hA5};
    do_reset(8'h00);
    foreach (p[i]) rom[i] = p[i];
    for (int i = 0; i < 65536; i++) dmem[i] = 8'(i) ^ 8'h3C;
    n_we = 0;
    n_re = 0;
    wait_pc(16'h0001);
    n = 0;
    while (o_pm_addr !== 16'h001E && n < 100) begin
      step();
      n++;
    end
    chk(16'(n), 16'h0023);
    repeat (3) step();
    foreach (ea[i]) begin
      chk(16'(dmem[ea[i]]), 16'(ev[i]));
    end
    chk(16'(n_we), 16'h0009);
    chk(16'(n_re), 16'h0005);
    $display("t_transfer done, mismatches %0d", n_mismatch);
  endtask : t_transfer

  // Program byte read through Z, odd address picks the high byte
  task automatic t_lpm();
    do_reset(8'h00);
    rom[0]  = f_ldi(5'h1E, 8'h21);
    rom[1]  = f_ldi(5'h1F, 8'h00);
    rom[2]  = OP_LPM;
    rom[3]  = f_ptr(1'h1, 5'h00, M_ABS);
    rom[4]  = 16'h0500;
    rom[16] = 16'hC35A;
    wait_pc(16'h0002);
    step();
    chk(o_pm_addr, 16'h0010);
    repeat (2) step();
    chk(o_pm_addr, 16'h0003);
    repeat (3) step();
    chk(16'(dmem[16'h0500]), 16'h00C3);
    $display("t_lpm done, mismatches %0d", n_mismatch);
  endtask : t_lpm

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  // Watchdog against a hung run
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    n_mismatch++;
    finish_test();
  end

  // Main sequence
  initial begin
    i_srst = 1'b1;
    i_status_flags = 8'h00;
    n_mismatch = 0;
    checked = 0;
    n_we = 0;
    n_re = 0;
    foreach (rom[i]) rom[i] = 16'h0000;
    t_branch();
    t_lpm();
    t_transfer();
    finish_test();
  end
endmodule : tb
